//--- cmw_ctrl.sv
/*
 mode, transmit relay, receive report and wake-up detection of a high-speed
 bus transceiver. assumes all inputs synchronous to clk; the analog comparators
 deliver bus_dominant, core_uv, io_uv, over_temp, temp_recovered as levels.
*/
// Contract
// RQ1: normal mode drives rx pin push-pull, low when dominant, high when recessive
// RQ2: standby releases rx push-pull; pin rests high via pull-up
// RQ3: after wake-up, push-pull resumes and reports; no-wake variant keeps high
// RQ4: normal with tx high keeps drivers off, bus recessive
// RQ5: normal with tx low turns drivers on, bus dominant
// RQ6: standby drivers off; wake variant terminates bus, else high-impedance
// RQ7: standby_select low gives normal, high or open gives standby
// RQ8: standby_select pulled up internally so open means standby
// RQ9: standby ignores tx and never drives the bus nor live rx
// RQ10: wake needs dominant > filter1, recessive > filter2, dominant > filter2
// RQ11: all three wake events within window timeout, else nothing reported
// RQ12: after wake, rx follows bus with longer toggle report delay
// RQ13: io undervoltage: unpowered, bus high-impedance, all activity stops
// RQ14: tx pulled up internally so open tx means recessive
// RQ15: tx low beyond dominant timeout disables drivers
// RQ16: after dominant timeout, tx high re-enables transmission
// RQ17: overtemp disables driver until cooled and tx high-to-low edge
// RQ18: core undervoltage forces standby; wake detection still works
// RQ19: standby to normal completes within 40 us
// RQ20: ready within 300 us after power-up
// RQ21: filter and timeout durations are cycle-count parameters
// RQ22: build options for wake-up support and dominant protection
`timescale 1ns/10ps
`include "cmw_cfg.svh"

module cmw_ctrl
    import cmw_pkg::*;
#(
    parameter bit          WAKE_EN   = 1'b1,                        // RQ22
    parameter bit          DOM_PROT  = 1'b1,                        // RQ22
    parameter int unsigned FLT1_CYC  = `CMW_WAKE_FLT1_CYC,          // RQ21
    parameter int unsigned FLT2_CYC  = `CMW_WAKE_FLT2_CYC,          // RQ21
    parameter int unsigned WIN_CYC   = `CMW_WAKE_WIN_CYC,           // RQ21
    parameter int unsigned DOM_CYC   = `CMW_DOM_TO_CYC,             // RQ21
    parameter int unsigned TGL_CYC   = `CMW_TOGGLE_DLY_CYC,
    parameter int unsigned SN_CYC    = `CMW_SN_DELAY_CYC,
    parameter int unsigned PWR_CYC   = `CMW_PWR_DELAY_CYC
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic standby_select,
    input  wire logic tx_data_in,
    input  wire logic bus_dominant,
    input  wire logic core_uv,
    input  wire logic io_uv,
    input  wire logic over_temp,
    input  wire logic temp_recovered,
    output logic      rx_data_out,
    output logic      rx_data_oe,
    output logic      bus_drive_on,
    output logic      bus_term_on,
    output logic      wake_reported,
    output logic      normal_active,
    output logic      device_ready
);

    cmw_state_t s_q;
    cmw_state_t s_d;

    // saturating increment shared by all timers except the 4-bit tgl_cnt
    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    logic stb_eff;
    logic tx_eff;

    // open pins: the pad pull-ups resolve to 1 before reaching here
    assign stb_eff = standby_select | core_uv;                      // RQ7 RQ8 RQ18
    assign tx_eff  = tx_data_in;                                    // RQ14

    always_comb
    begin
        s_d = s_q;
        s_d.tx_prev = tx_eff;
        s_d.ready = s_q.ready | (s_q.mode_cnt >= 16'(PWR_CYC));

        // mode sequencing
        case (s_q.mode)
            CMW_OFF:
            begin
                s_d.mode_cnt = inc16(s_q.mode_cnt);
                if (s_q.mode_cnt >= 16'(PWR_CYC))                   // RQ20
                begin
                    s_d.mode = CMW_STANDBY;
                    s_d.mode_cnt = 16'h0000;
                end
            end
            CMW_STANDBY:
            begin
                s_d.mode_cnt = 16'h0000;
                if (!stb_eff)
                    s_d.mode = CMW_TO_NORM;
            end
            CMW_TO_NORM:
            begin
                // settle the bias before driving; bounded by the 40 us limit
                s_d.mode_cnt = inc16(s_q.mode_cnt);
                if (stb_eff)
                    s_d.mode = CMW_STANDBY;
                else if (s_q.mode_cnt + 16'h0001 >= 16'(SN_CYC))    // RQ19
                    s_d.mode = CMW_NORMAL;
            end
            CMW_NORMAL:
            begin
                if (stb_eff)
                    s_d.mode = CMW_STANDBY;                         // RQ7 RQ18
            end
            default: s_d.mode = CMW_OFF;
        endcase

        // dominant timeout lock
        if (DOM_PROT && s_q.mode == CMW_NORMAL && !tx_eff)
            s_d.dom_cnt = inc16(s_q.dom_cnt);
        else
            s_d.dom_cnt = 16'h0000;
        if (DOM_PROT && s_q.dom_cnt >= 16'(DOM_CYC))
            s_d.dom_lock = 1'b1;                                    // RQ15
        else if (tx_eff)
            s_d.dom_lock = 1'b0;                                    // RQ16

        // overtemperature lock, re-armed by a falling tx edge once cooled
        if (over_temp)
            s_d.ot_lock = 1'b1;                                     // RQ17
        else if (s_q.ot_lock && temp_recovered && s_q.tx_prev && !tx_eff)
            s_d.ot_lock = 1'b0;                                     // RQ17

        // wake-up detector, runs only in standby of a wake-capable build
        s_d.flt_cnt = inc16(s_q.flt_cnt);
        if (s_q.wst != CMW_W_IDLE)
            s_d.win_cnt = inc16(s_q.win_cnt);
        if (!WAKE_EN || s_q.mode != CMW_STANDBY)
        begin
            s_d.wst = CMW_W_IDLE;
            s_d.woke = 1'b0;
            s_d.win_cnt = 16'h0000;
            s_d.flt_cnt = 16'h0000;
        end
        else if (!s_q.woke)
        begin
            case (s_q.wst)
                CMW_W_IDLE:
                begin
                    s_d.flt_cnt = 16'h0000;
                    s_d.win_cnt = 16'h0000;
                    if (bus_dominant)
                        s_d.wst = CMW_W_DOM1;
                end
                CMW_W_DOM1:
                begin
                    if (!bus_dominant)
                    begin
                        s_d.flt_cnt = 16'h0000;
                        s_d.wst = (s_q.flt_cnt > 16'(FLT1_CYC)) ?   // RQ10
                                  CMW_W_REC2 : CMW_W_IDLE;
                    end
                end
                CMW_W_REC2:
                begin
                    if (bus_dominant)
                    begin
                        s_d.flt_cnt = 16'h0000;
                        // a short recessive glitch returns to event 1, whose filter restarts from zero
                        s_d.wst = (s_q.flt_cnt > 16'(FLT2_CYC)) ?   // RQ10
                                  CMW_W_DOM3 : CMW_W_DOM1;
                    end
                end
                CMW_W_DOM3:
                begin
                    if (s_q.flt_cnt > 16'(FLT2_CYC))
                        s_d.woke = 1'b1;                            // RQ10
                    else if (!bus_dominant)
                    begin
                        s_d.flt_cnt = 16'h0000;
                        s_d.wst = CMW_W_REC2;
                    end
                end
                default: s_d.wst = CMW_W_IDLE;
            endcase
            // a stuck dominant bus never completes the pattern in time
            if (s_q.wst != CMW_W_IDLE && s_q.win_cnt >= 16'(WIN_CYC)
                && !(s_q.wst == CMW_W_DOM3 && s_q.flt_cnt > 16'(FLT2_CYC)))
            begin
                s_d.wst = CMW_W_IDLE;                               // RQ11
                s_d.win_cnt = 16'h0000;
            end
        end

        // toggle report: rx follows the bus after a longer delay
        if (s_q.woke && ((!bus_dominant) != s_q.rx_q))
        begin
            s_d.tgl_cnt = s_q.tgl_cnt + 4'h1;
            if (s_q.tgl_cnt + 4'h1 >= 4'(TGL_CYC))
            begin
                s_d.rx_q = !bus_dominant;                           // RQ12
                s_d.tgl_cnt = 4'h0;
            end
        end
        else
            s_d.tgl_cnt = 4'h0;

        // pin drive
        if (s_q.mode == CMW_NORMAL)
        begin
            s_d.rx_q  = !bus_dominant;                              // RQ1
            s_d.rx_oe = 1'b1;                                       // RQ1
        end
        else if (s_q.woke)
            s_d.rx_oe = 1'b1;                                       // RQ3
        else
        begin
            s_d.rx_q  = 1'b1;                                       // RQ2 RQ9
            s_d.rx_oe = 1'b0;                                       // RQ2
        end

        s_d.drv_on = (s_q.mode == CMW_NORMAL) && !tx_eff            // RQ4 RQ5 RQ9
                     && !s_d.dom_lock && !s_d.ot_lock;              // RQ15 RQ17
        s_d.term_on = WAKE_EN && (s_q.mode != CMW_NORMAL)           // RQ6
                      && (s_q.mode != CMW_OFF);

        if (io_uv)
        begin
            s_d = '0;                                               // RQ13
            s_d.rx_q = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.rx_q <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign rx_data_out   = s_q.rx_q;
    assign rx_data_oe    = s_q.rx_oe;
    assign bus_drive_on  = s_q.drv_on;
    assign bus_term_on   = s_q.term_on;
    assign wake_reported = s_q.woke;
    assign normal_active = (s_q.mode == CMW_NORMAL);
    assign device_ready  = s_q.ready;

endmodule // cmw_ctrl

//--- cmw_cfg.svh
/*
 constants of the transceiver mode and wake-up control: timing figures and
 cycle counts at a 10 MHz clock; assumes a single clock domain
*/
`ifndef CMW_CFG_SVH
`define CMW_CFG_SVH

`define CMW_CLK_MHZ          10
// wake filters in ns, timeouts in us
`define CMW_WAKE_FLT1_NS     500
`define CMW_WAKE_FLT2_NS     80
`define CMW_WAKE_WIN_US      1500
`define CMW_DOM_TO_US        2500
`define CMW_TOGGLE_DLY_NS    1300
`define CMW_SN_DELAY_US      40
`define CMW_PWR_DELAY_US     300
// least times round up, longest times round down
`define CMW_WAKE_FLT1_CYC    ((`CMW_WAKE_FLT1_NS * `CMW_CLK_MHZ + 999) / 1000)
`define CMW_WAKE_FLT2_CYC    ((`CMW_WAKE_FLT2_NS * `CMW_CLK_MHZ + 999) / 1000)
`define CMW_WAKE_WIN_CYC     (`CMW_WAKE_WIN_US * `CMW_CLK_MHZ)
`define CMW_DOM_TO_CYC       (`CMW_DOM_TO_US * `CMW_CLK_MHZ)
`define CMW_TOGGLE_DLY_CYC   ((`CMW_TOGGLE_DLY_NS * `CMW_CLK_MHZ) / 1000)
`define CMW_SN_DELAY_CYC     (`CMW_SN_DELAY_US * `CMW_CLK_MHZ)
`define CMW_PWR_DELAY_CYC    (`CMW_PWR_DELAY_US * `CMW_CLK_MHZ)

`endif

//--- cmw_pkg.sv
/*
 types of the transceiver mode and wake-up control
 assumes cmw_cfg.svh for all figures
*/
package cmw_pkg;
    typedef enum logic [1:0] {
        CMW_OFF     = 2'b00,
        CMW_STANDBY = 2'b01,
        CMW_TO_NORM = 2'b10,
        CMW_NORMAL  = 2'b11
    } cmw_mode_t;

    typedef enum logic [1:0] {
        CMW_W_IDLE = 2'b00,
        CMW_W_DOM1 = 2'b01,
        CMW_W_REC2 = 2'b10,
        CMW_W_DOM3 = 2'b11
    } cmw_wake_t;

    typedef struct packed {
        cmw_mode_t   mode;
        cmw_wake_t   wst;
        logic        woke;
        logic [15:0] win_cnt;
        logic [15:0] flt_cnt;
        logic [15:0] mode_cnt;
        logic [15:0] dom_cnt;
        logic        dom_lock;
        logic        ot_lock;
        logic        tx_prev;
        logic [3:0]  tgl_cnt;
        logic        rx_q;
        logic        rx_oe;
        logic        drv_on;
        logic        term_on;
        logic        ready;
    } cmw_state_t;
endpackage

//--- cmw_ctrl_asserts.sv
/* assertions on the cmw_ctrl ports
   bound to every cmw_ctrl, mode delay parameter handed on */
`timescale 1ns/10ps
module cmw_ctrl_asserts #(parameter int unsigned SN_CYC = 4)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic standby_select,
    input wire logic tx_data_in,
    input wire logic bus_dominant,
    input wire logic core_uv,
    input wire logic io_uv,
    input wire logic over_temp,
    input wire logic temp_recovered,
    input wire logic rx_data_out,
    input wire logic rx_data_oe,
    input wire logic bus_drive_on,
    input wire logic bus_term_on,
    input wire logic wake_reported,
    input wire logic normal_active,
    input wire logic device_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [15:0] sn_q;
    wire logic go = !standby_select && device_ready && !core_uv && !io_uv && !normal_active;
    // cycles spent waiting for normal mode
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            sn_q <= 16'h0000;
        else
            sn_q <= go ? sn_q + 16'h0001 : 16'h0000;
    property p_rxf;
        normal_active[*2] |-> rx_data_oe && rx_data_out != $past(bus_dominant);
    endproperty
    a_rxf: assert property (p_rxf) else $error("rx not following bus");
    property p_rel; !rx_data_oe |-> rx_data_out; endproperty
    a_rel: assert property (p_rel) else $error("released rx not high");
    property p_qt; !normal_active[*3] |-> !bus_drive_on; endproperty
    a_qt: assert property (p_qt) else $error("drive outside normal");
    property p_rec; normal_active[*2] ##0 $past(tx_data_in) |-> !bus_drive_on; endproperty
    a_rec: assert property (p_rec) else $error("drive with tx high");
    property p_trm; normal_active[*2] |-> !bus_term_on; endproperty
    a_trm: assert property (p_trm) else $error("termination in normal");
    property p_io;
        io_uv |=> !bus_drive_on && !bus_term_on && !rx_data_oe && !wake_reported;
    endproperty
    a_io: assert property (p_io) else $error("activity while unpowered");
    property p_cuv; core_uv[*3] |-> !normal_active; endproperty
    a_cuv: assert property (p_cuv) else $error("normal under core uv");
    property p_sn; sn_q <= SN_CYC + 3; endproperty
    a_sn: assert property (p_sn) else $error("normal entry too slow");
endmodule // cmw_ctrl_asserts

bind cmw_ctrl cmw_ctrl_asserts #(.SN_CYC(SN_CYC)) u_chk (.*);

//--- cmw_mcu_model.sv
/* protocol controller side: drives the mode and transmit pins
   assumes bench commands, applied one clock later */
`timescale 1ns/10ps
module cmw_mcu_model (
    input  wire logic clk,
    input  wire logic stb_cmd,
    input  wire logic tx_cmd,
    output logic      standby_select,
    output logic      tx_data_in
);
    // pins idle high, as an unconnected controller leaves them
    initial standby_select = 1'b1;
    initial tx_data_in = 1'b1;
    always @(posedge clk)
    begin
        standby_select <= stb_cmd;
        tx_data_in     <= tx_cmd;
    end
endmodule // cmw_mcu_model

//--- test_cmw_ctrl.sv
/* self-checking bench of cmw_ctrl with shortened counts
   assumes cmw_mcu_model in front of the mode and transmit pins */
`timescale 1ns/10ps
module test_cmw_ctrl;
    localparam int unsigned SN = 4;
    localparam int unsigned DOM = 50;
    localparam int unsigned WIN = 200;
    logic clk = 1'b0, rstn = 1'b0, stb_cmd = 1'b1, tx_cmd = 1'b1, bus_dominant = 1'b0;
    logic core_uv = 1'b0, io_uv = 1'b0, over_temp = 1'b0, temp_recovered = 1'b0;
    logic standby_select, tx_data_in, rx_data_out, rx_data_oe, bus_drive_on;
    logic bus_term_on, wake_reported, normal_active, device_ready;
    int error_cnt = 0, checked = 0, cyc_n = 0;
    always #50 clk = ~clk;
    cmw_mcu_model u_mcu (.*);
    cmw_ctrl #(.WIN_CYC(WIN), .DOM_CYC(DOM), .SN_CYC(SN), .PWR_CYC(5)) uut (.*);
    task automatic chk(input string n, input logic s, input logic e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_relay;
        stb_cmd <= 1'b0;
        cy(SN + 6);
        chk("normal", normal_active, 1'b1);
        tx_cmd <= 1'b0;
        bus_dominant <= 1'b1;
        cy(4);
        chk("drive", bus_drive_on, 1'b1);
        chk("rx", rx_data_out, 1'b0);
        cy(DOM);
        chk("drive", bus_drive_on, 1'b0);
        tx_cmd <= 1'b1;
        bus_dominant <= 1'b0;
        cy(3);
        chk("rx", rx_data_out, 1'b1);
        tx_cmd <= 1'b0;
        cy(4);
        chk("drive", bus_drive_on, 1'b1);
    endtask
    task automatic t_hot;
        over_temp <= 1'b1;
        cy(3);
        over_temp <= 1'b0;
        // a falling tx edge before the die has cooled must not re-arm the driver
        tx_cmd <= 1'b1;
        cy(3);
        tx_cmd <= 1'b0;
        cy(4);
        chk("drive", bus_drive_on, 1'b0);
        temp_recovered <= 1'b1;
        cy(4);
        chk("drive", bus_drive_on, 1'b0);
        tx_cmd <= 1'b1;
        cy(3);
        tx_cmd <= 1'b0;
        cy(4);
        chk("drive", bus_drive_on, 1'b1);
        stb_cmd <= 1'b1;
        temp_recovered <= 1'b0;
        cy(6);
        chk("drive", bus_drive_on, 1'b0);
        chk("oe", rx_data_oe, 1'b0);
        chk("rx", rx_data_out, 1'b1);
        chk("term", bus_term_on, 1'b1);
        tx_cmd <= 1'b1;
    endtask
    task automatic pat(input int gap);
        bus_dominant <= 1'b1;
        cy(8);
        bus_dominant <= 1'b0;
        cy(4 + gap);
        bus_dominant <= 1'b1;
        cy(6);
    endtask
    task automatic t_wake;
        pat(WIN);
        chk("wake", wake_reported, 1'b0);
        bus_dominant <= 1'b0;
        cy(4);
        pat(0);
        chk("wake", wake_reported, 1'b1);
        chk("oe", rx_data_oe, 1'b1);
        cy(17);
        chk("rx", rx_data_out, 1'b0);
        bus_dominant <= 1'b0;
        cy(17);
        chk("rx", rx_data_out, 1'b1);
    endtask
    task automatic t_supply;
        stb_cmd <= 1'b0;
        cy(SN + 6);
        core_uv <= 1'b1;
        cy(4);
        chk("normal", normal_active, 1'b0);
        core_uv <= 1'b0;
        tx_cmd <= 1'b0;
        cy(SN + 8);
        io_uv <= 1'b1;
        cy(3);
        chk("drive", bus_drive_on, 1'b0);
        chk("ready", device_ready, 1'b0);
        io_uv <= 1'b0;
    endtask
    initial
    begin
        cy(4);
        rstn <= 1'b1;
        cy(9);
        chk("ready", device_ready, 1'b1);
        chk("normal", normal_active, 1'b0);
        t_relay();
        t_hot();
        t_wake();
        t_supply();
        report_and_stop();
    end
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
endmodule // test_cmw_ctrl
